// file: tcmcc_top.sv
// conversion sequencer, configuration word and result registers
`include "tcmcc_params.svh"
module tcmcc_top #(
  parameter logic [7:0][18:0] CONV_CYC = {
    19'(`TCMCC_CT7_NS / `TCMCC_CLK_NS),
    19'(`TCMCC_CT6_NS / `TCMCC_CLK_NS),
    19'(`TCMCC_CT5_NS / `TCMCC_CLK_NS),
    19'(`TCMCC_CT4_NS / `TCMCC_CLK_NS),
    19'(`TCMCC_CT3_NS / `TCMCC_CLK_NS),
    19'(`TCMCC_CT2_NS / `TCMCC_CLK_NS),
    19'(`TCMCC_CT1_NS / `TCMCC_CLK_NS),
    19'(`TCMCC_CT0_NS / `TCMCC_CLK_NS)
  }
) (
  input wire logic mclk, // 40 MHz clock
  input wire logic rst_b, // synchronous reset, active low
  input wire tcmcc_pkg::tcmcc_reg_req_t regReq, // register access strobe
  input wire logic wrSeqBusy, // serial write sequence in flight
  input wire logic signed [12:0] adcSample, // converter sample
  output logic [15:0] regRdData, // read word
  output logic regRdValid, // read word valid pulse
  output logic adcConv, // conversion running
  output tcmcc_pkg::tcmcc_adc_sel_t adcSel // converter input select
);
  import tcmcc_pkg::*;

  tcmcc_cfg_t cfg_r, cfg_nxt;
  tcmcc_state_t state_r, state_nxt;
  logic [2:0] slot_r, slot_nxt;
  logic [18:0] cnt_r, cnt_nxt;
  logic [9:0] smp_r, smp_nxt;
  logic signed [23:0] acc_r, acc_nxt;
  logic trigPend_r, trigPend_nxt;
  logic rdPend_r;
  logic [1:0] rdSel_r;
  logic [15:0] cfgSnap_r;
  logic [15:0] regRdData_r;
  logic regRdValid_r;
  logic adcConv_r;
  tcmcc_adc_sel_t adcSel_r;
  logic [15:0] memRdata;

  // slot = channel * 2 + quantity, quantity 1 is bus
  function automatic logic slotOn(input tcmcc_cfg_t c, input logic [2:0] s);
    logic chOn;
    logic qOn;
    chOn = 1'b0;
    case (s[2:1])
      2'h0: chOn = c.channelOnBits[2];
      2'h1: chOn = c.channelOnBits[1];
      2'h2: chOn = c.channelOnBits[0];
      default: chOn = 1'b0;
    endcase
    qOn = s[0] ? c.opSelectBit1 : c.opSelectBit0;
    return chOn && qOn;
  endfunction : slotOn

  // lowest enabled slot at or above the start, with a found flag on top
  function automatic logic [3:0] nextOn(input tcmcc_cfg_t c,
                                        input logic [3:0] from);
    logic [3:0] r;
    r = 4'h0;
    for (int i = `TCMCC_SLOTS - 1; i >= 0; i--) begin
      if (4'(i) >= from && slotOn(c, 3'(i))) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction : nextOn

  function automatic logic [3:0] avgShift(input logic [2:0] code);
    logic [3:0] s;
    case (code)
      3'h0: s = 4'h0;
      3'h1: s = 4'h2;
      3'h2: s = 4'h4;
      3'h3: s = 4'h6;
      3'h4: s = 4'h7;
      3'h5: s = 4'h8;
      3'h6: s = 4'h9;
      default: s = 4'ha;
    endcase
    return s;
  endfunction : avgShift

  // register decode
  wire cfgHit = regReq.addr == `TCMCC_OFF_CFG;
  wire cfgWr = regReq.wr && cfgHit;
  wire softRst = cfgWr && regReq.wdata[`TCMCC_RST_BIT];
  wire abort = cfgWr || wrSeqBusy;
  wire resHit = regReq.addr == `TCMCC_OFF_SH1 ||
                regReq.addr == `TCMCC_OFF_BUS1 ||
                regReq.addr == `TCMCC_OFF_SH2;
  wire [2:0] rdSlot = regReq.addr[2:0] - 3'h1;
  wire [1:0] rdSelNxt = cfgHit ? 2'h1 : (resHit ? 2'h2 : 2'h0);
  wire memClr = !rst_b || softRst;

  // sequencing decode
  wire runMode = cfg_r.opSelectBit1 || cfg_r.opSelectBit0;
  wire contMode = cfg_r.opSelectBit2;
  wire [3:0] firstHit = nextOn(cfg_r, 4'h0);
  wire [3:0] laterHit = nextOn(cfg_r, {1'b0, slot_r} + 4'h1);
  wire [3:0] shift = avgShift(cfg_r.sampleAverageCount);
  wire [9:0] smpLast = 10'((11'h1 << shift) - 11'h1);
  wire [2:0] ctSel = slot_r[0] ? cfg_r.busConversionTime :
                     cfg_r.shuntConversionTime;
  wire [18:0] convCyc = CONV_CYC[ctSel];
  wire convEnd = cnt_r == convCyc - 19'h1;
  wire signed [23:0] accSum = acc_r + {{11{adcSample[12]}}, adcSample};
  wire signed [23:0] avgFull = acc_r >>> shift;
  wire [15:0] resWord = {avgFull[12:0], 3'h0};
  wire memWe = state_r == ST_STORE && !abort;
  wire startOk = state_r == ST_IDLE && !abort && runMode &&
                 (contMode || trigPend_r) && firstHit[3];

  always_comb begin
    cfg_nxt = cfg_r;
    if (softRst) begin
      cfg_nxt = tcmcc_cfg_t'(`TCMCC_CFG_RESET); // RL14
    end else if (cfgWr) begin
      cfg_nxt = tcmcc_cfg_t'(regReq.wdata); // RL1 RL2 RL3 RL4 RL13
      cfg_nxt.rst = 1'b0; // RL14
    end
  end

  always_comb begin
    state_nxt = state_r;
    slot_nxt = slot_r;
    cnt_nxt = cnt_r;
    smp_nxt = smp_r;
    acc_nxt = acc_r;
    trigPend_nxt = trigPend_r;
    case (state_r)
      ST_IDLE: begin
        if (startOk) begin
          state_nxt = ST_CONV; // RL15
          slot_nxt = firstHit[2:0]; // RL8
          cnt_nxt = 19'h0;
          smp_nxt = 10'h0;
          acc_nxt = 24'h0;
          trigPend_nxt = 1'b0;
        end
      end
      ST_CONV: begin
        if (convEnd) begin
          cnt_nxt = 19'h0; // RL2 RL3
          acc_nxt = accSum; // RL11
          if (smp_r == smpLast) begin
            state_nxt = ST_STORE; // RL1
          end else begin
            smp_nxt = smp_r + 10'h1;
          end
        end else begin
          cnt_nxt = cnt_r + 19'h1;
        end
      end
      ST_STORE: begin
        if (laterHit[3]) begin
          state_nxt = ST_CONV; // RL8
          slot_nxt = laterHit[2:0];
          smp_nxt = 10'h0;
          acc_nxt = 24'h0;
        end else begin
          state_nxt = ST_IDLE; // RL15
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (abort) begin
      state_nxt = ST_IDLE; // RL7
      cnt_nxt = 19'h0;
      smp_nxt = 10'h0;
      acc_nxt = 24'h0;
    end
    if (cfgWr) begin
      trigPend_nxt = !softRst; // RL7
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cfg_r <= tcmcc_cfg_t'(`TCMCC_CFG_RESET); // RL5 RL13
      state_r <= ST_IDLE;
      slot_r <= 3'h0;
      cnt_r <= 19'h0;
      smp_r <= 10'h0;
      acc_r <= 24'h0;
      trigPend_r <= 1'b0;
      adcConv_r <= 1'b0;
      adcSel_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
      state_r <= state_nxt;
      slot_r <= slot_nxt;
      cnt_r <= cnt_nxt;
      smp_r <= smp_nxt;
      acc_r <= acc_nxt;
      trigPend_r <= trigPend_nxt;
      adcConv_r <= state_nxt == ST_CONV;
      adcSel_r <= {slot_nxt[2:1], slot_nxt[0]};
    end
  end

  // read pipeline: snapshot at request, word out two edges later
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdPend_r <= 1'b0;
      rdSel_r <= 2'h0;
      cfgSnap_r <= 16'h0000;
      regRdData_r <= 16'h0000;
      regRdValid_r <= 1'b0;
    end else begin
      rdPend_r <= regReq.rd;
      rdSel_r <= rdSelNxt;
      cfgSnap_r <= cfg_r; // RL6
      regRdValid_r <= rdPend_r;
      if (rdPend_r) begin
        regRdData_r <= rdSel_r == 2'h1 ? cfgSnap_r :
                       (rdSel_r == 2'h2 ? memRdata : 16'h0000);
      end
    end
  end

  // results: 01h ch1 shunt, 02h ch1 bus, 03h ch2 shunt
  tcmcc_result_mem u_mem (
    .clk(mclk),
    .clr(memClr),
    .we(memWe), // RL16
    .waddr(slot_r), // RL9 RL12
    .wdata(resWord), // RL10
    .raddr(rdSlot),
    .rdata(memRdata)
  );

  assign regRdData = regRdData_r;
  assign regRdValid = regRdValid_r;
  assign adcConv = adcConv_r;
  assign adcSel = adcSel_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_avg_last_sample: assert property ( // RL1
    state_r == ST_CONV && convEnd && !abort && smp_r == smpLast
    |=> state_r == ST_STORE)
    else $error("average did not end on last sample");
  a_conv_time_bus: assert property ( // RL2
    $rose(adcConv_r) && adcSel_r.isBus && cfg_r.busConversionTime == 3'h0
    && !abort ##1 !abort |-> cnt_r == 19'h1)
    else $error("bus conversion timer not started");
  a_powerdown_quiet: assert property ( // RL4
    !runMode && state_r == ST_IDLE && !cfgWr |=> !adcConv_r)
    else $error("conversion started in power-down");
  a_reset_defaults: assert property (@(posedge mclk) disable iff (1'b0) // RL5
    !rst_b |=> cfg_r == `TCMCC_CFG_RESET && !regRdValid)
    else $error("configuration default wrong after reset");
  a_read_harmless: assert property ( // RL6
    regReq.rd && !regReq.wr && !wrSeqBusy && state_r == ST_CONV && !convEnd
    |=> $stable(cfg_r) && state_r == ST_CONV &&
    cnt_r == $past(cnt_r) + 19'h1)
    else $error("read disturbed settings or conversion");
  a_write_aborts: assert property ( // RL7
    cfgWr |=> state_r == ST_IDLE && !adcConv_r && acc_r == 24'h0)
    else $error("write did not halt conversion");
  a_channel_gate: assert property ( // RL8
    adcConv_r |-> slotOn(cfg_r, {adcSel_r.chan, adcSel_r.isBus}))
    else $error("disabled channel converted");
  a_result_layout: assert property ( // RL10
    memWe |-> resWord[2:0] == 3'h0 && resWord[15] == acc_r[23])
    else $error("result word layout wrong");
  a_read_latency: assert property ( // RL9
    regReq.rd |-> ##2 regRdValid)
    else $error("read answer not two cycles later");
  a_valid_from_read: assert property ( // RL9
    regRdValid |-> $past(regReq.rd, 2))
    else $error("read answer without a read");
  a_soft_reset: assert property ( // RL14
    softRst |=> cfg_r == `TCMCC_CFG_RESET && !cfg_r.rst && !trigPend_r)
    else $error("soft reset did not restore defaults");
  a_trig_one_shot: assert property ( // RL15
    memWe && !contMode && !laterHit[3] |=> state_r == ST_IDLE ##1
    (state_r == ST_IDLE || trigPend_r || abort || $past(abort)))
    else $error("triggered mode ran a second sequence");
endmodule : tcmcc_top

// file: tcmcc_params.svh
// constants for the monitor conversion-control block
// Contract
// [RL1] averaging field bits 11:9 picks 1 to 1024 samples, resets to one
// [RL2] bus conversion time field bits 8:6 picks 140 us to 8.244 ms
// [RL3] shunt conversion time field bits 5:3, same times, resets to 1.1 ms
// [RL4] mode bits 2:0: 0/4 power-down, 1-3 triggered, 5-7 continuous
// [RL5] mode field resets to continuous shunt and bus
// [RL6] reading the configuration word changes nothing and disturbs nothing
// [RL7] configuration write halts conversion, then restarts with new settings
// [RL8] only enabled channels take part in the measurement sequence
// [RL9] channel 1 shunt at 01h, channel 2 shunt at 03h, read-only
// [RL10] result is sign at 15, magnitude 14:3, low three bits zero
// [RL11] negative results are two's complement with sign extended
// [RL12] channel 1 bus reading at 02h, same signed layout
// [RL13] bits 14:12 enable channels one to three, all on after reset
// [RL14] writing bit 15 resets everything to defaults and self-clears
// [RL15] triggered runs one sequence per write; power-down starts nothing
// [RL16] results read zero after reset, update only on finished average
`ifndef TCMCC_PARAMS_SVH
`define TCMCC_PARAMS_SVH
`define TCMCC_OFF_CFG 8'h00
`define TCMCC_OFF_SH1 8'h01
`define TCMCC_OFF_BUS1 8'h02
`define TCMCC_OFF_SH2 8'h03
`define TCMCC_CFG_RESET 16'h7127
`define TCMCC_RES_RESET 16'h0000
`define TCMCC_RST_BIT 15
`define TCMCC_CHANNEL_ON_BITS_LO 12
`define TCMCC_AVG_LO 9
`define TCMCC_BCT_LO 6
`define TCMCC_SCT_LO 3
`define TCMCC_MODE_LO 0
`define TCMCC_SLOTS 6
`define TCMCC_CLK_NS 25
`define TCMCC_CT0_NS 140000
`define TCMCC_CT1_NS 204000
`define TCMCC_CT2_NS 332000
`define TCMCC_CT3_NS 588000
`define TCMCC_CT4_NS 1100000
`define TCMCC_CT5_NS 2116000
`define TCMCC_CT6_NS 4156000
`define TCMCC_CT7_NS 8244000
`endif

// file: tcmcc_pkg.sv
// types shared by the monitor conversion-control block
package tcmcc_pkg;
  typedef struct packed {
    logic rst;
    logic [2:0] channelOnBits;
    logic [2:0] sampleAverageCount;
    logic [2:0] busConversionTime;
    logic [2:0] shuntConversionTime;
    logic opSelectBit2;
    logic opSelectBit1;
    logic opSelectBit0;
  } tcmcc_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } tcmcc_reg_req_t;

  typedef struct packed {
    logic [1:0] chan;
    logic isBus;
  } tcmcc_adc_sel_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_STORE = 3'b100
  } tcmcc_state_t;
endpackage : tcmcc_pkg

// file: tcmcc_result_mem.sv
// result word store, one word per channel and quantity
`include "tcmcc_params.svh"
module tcmcc_result_mem (
  input wire logic clk, // clock
  input wire logic clr, // synchronous clear of all words
  input wire logic we, // write strobe
  input wire logic [2:0] waddr, // write slot
  input wire logic [15:0] wdata, // write word
  input wire logic [2:0] raddr, // read slot
  output logic [15:0] rdata // registered read word
);
  logic [15:0] mem_r [`TCMCC_SLOTS];
  logic [15:0] rdata_r;
  wire inRange = raddr < 3'(`TCMCC_SLOTS);

  always_ff @(posedge clk) begin
    if (clr) begin
      for (int i = 0; i < `TCMCC_SLOTS; i++) begin
        mem_r[i] <= `TCMCC_RES_RESET; // RL16
      end
    end else if (we && waddr < 3'(`TCMCC_SLOTS)) begin
      mem_r[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (clr || !inRange) begin
      rdata_r <= `TCMCC_RES_RESET;
    end else begin
      rdata_r <= mem_r[raddr];
    end
  end

  assign rdata = rdata_r;
endmodule : tcmcc_result_mem

// file: tcmcc_adc_model.sv
// converter front-end model feeding one fixed level per slot
module tcmcc_adc_model (
  input wire logic adcConv, // conversion running
  input wire tcmcc_pkg::tcmcc_adc_sel_t adcSel, // selected input
  output logic signed [12:0] adcSample // sample to the sequencer
);
  timeunit 1ns;
  timeprecision 1ns;
  import tcmcc_pkg::*;
  logic signed [12:0] slotVal;
  always_comb begin
    case ({adcSel.chan, adcSel.isBus})
      3'b000: slotVal = 13'h1830; // ch1 shunt, minus 2000 steps
      3'b001: slotVal = 13'h0fff; // ch1 bus, full scale
      3'b010: slotVal = 13'h0155; // ch2 shunt
      default: slotVal = 13'h0abc;
    endcase
  end
  // outside a conversion the line shows a wrong level on purpose
  assign adcSample = adcConv ? slotVal : ~slotVal;
endmodule : tcmcc_adc_model

// file: tb_top.sv
// self-checking bench for the conversion-control block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import tcmcc_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  tcmcc_reg_req_t regReq = '0;
  logic wrSeqBusy = 1'b0;
  logic signed [12:0] adcSample;
  logic [15:0] regRdData;
  logic regRdValid;
  logic adcConv;
  tcmcc_adc_sel_t adcSel;
  logic [15:0] rdVal;
  int error_cnt = 0;
  int check_count = 0;
  int cycCnt = 0;
  int cycN;

  tcmcc_top #(.CONV_CYC({19'h0a, 19'h09, 19'h08, 19'h07,
                         19'h06, 19'h05, 19'h04, 19'h03})) u_tcmcc_top (
    .mclk(mclk), .rst_b(rst_b), .regReq(regReq), .wrSeqBusy(wrSeqBusy),
    .adcSample(adcSample), .regRdData(regRdData),
    .regRdValid(regRdValid), .adcConv(adcConv), .adcSel(adcSel));
  tcmcc_adc_model u_tcmcc_adc_model (
    .adcConv(adcConv), .adcSel(adcSel), .adcSample(adcSample));

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  task automatic test_done;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  always @(posedge mclk) begin
    cycCnt++;
    if (cycCnt == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    tick(1);
    regReq = {1'b1, 1'b0, a, d};
    tick(1);
    regReq.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    d = 16'hdead;
    tick(1);
    regReq = {1'b0, 1'b1, a, 16'h0000};
    tick(1);
    regReq.rd = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (regRdValid === 1'b1) begin
        d = regRdData;
        break;
      end
      tick(1);
    end
  endtask : rd

  // poll a result word until it shows the expected level, bounded
  task automatic waitRes(input logic [7:0] a, input logic [15:0] exp);
    for (int i = 0; i < 80; i++) begin
      rd(a, rdVal);
      if (rdVal === exp) break;
    end
    chk(rdVal, exp);
  endtask : waitRes

  // cycles with the converter busy after a write, and the channel it picked
  task automatic convLen(output int n, output logic [15:0] ch);
    n = 0;
    tick(1);
    ch = 16'(adcSel.chan);
    while (adcConv === 1'b1 && n < 100) begin
      n++;
      tick(1);
    end
  endtask : convLen

  initial begin
    tick(5);
    rst_b = 1'b1;
    rd(8'h00, rdVal);
    chk(rdVal, 16'h7127);
    rd(8'h01, rdVal);
    chk(rdVal, 16'h0000);
    waitRes(8'h01, 16'hc180);
    waitRes(8'h02, 16'h7ff8);
    waitRes(8'h03, 16'h0aa8);
    rd(8'h10, rdVal);
    chk(rdVal, 16'h0000);
    wr(8'h01, 16'h1234);
    rd(8'h01, rdVal);
    chk(rdVal, 16'hc180);
    rd(8'h00, rdVal);
    chk(rdVal, 16'h7127);
    wr(8'h00, 16'h8000);
    rd(8'h01, rdVal);
    chk(rdVal, 16'h0000);
    rd(8'h00, rdVal);
    chk(rdVal, 16'h7127);
    // a write sequence in flight holds the sequencer off
    wrSeqBusy = 1'b1;
    tick(2);
    for (int i = 0; i < 10; i++) begin
      chk(16'(adcConv), 16'h0000);
      tick(1);
    end
    wrSeqBusy = 1'b0;
    waitRes(8'h01, 16'hc180);
    for (int m = 0; m < 8; m++) begin
      wr(8'h00, 16'h7120 | 16'(m));
      tick(3);
      chk(16'(adcConv), 16'(m % 4 != 0));
      if (m % 4 != 0) begin
        chk(16'(adcSel.isBus), 16'(m % 4 == 2));
      end
    end
    wr(8'h00, 16'h8000);
    wr(8'h00, 16'h2201);
    // four shunt samples of three cycles each, channel 2 only
    convLen(cycN, rdVal);
    chk(16'(cycN), 16'h000c);
    chk(rdVal, 16'h0001);
    waitRes(8'h03, 16'h0aa8);
    rd(8'h01, rdVal);
    chk(rdVal, 16'h0000);
    tick(40);
    chk(16'(adcConv), 16'h0000);
    // one bus sample at the fastest time code, channel 1 only
    wr(8'h00, 16'h4002);
    convLen(cycN, rdVal);
    chk(16'(cycN), 16'h0003);
    chk(rdVal, 16'h0000);
    waitRes(8'h02, 16'h7ff8);
    test_done();
  end
endmodule : tb_top
